// *** hdl/i2c_link_if.sv ***
`timescale 1ns/1ns
interface i2c_link_if;
    logic host_scl_o;  // host clock level when driving
    logic host_scl_oe; // host pulls the clock line
    logic host_sda_o;  // host data level when driving
    logic host_sda_oe; // host pulls the data line
    logic tgt_sda_o;   // target data level when driving
    logic tgt_sda_oe;  // target pulls the data line
    logic scl;         // resolved clock wire
    logic sda;         // resolved data wire

    // open drain wires with pullups: idle high unless someone pulls low
    assign scl = !(host_scl_oe && !host_scl_o);
    assign sda = !(host_sda_oe && !host_sda_o) && !(tgt_sda_oe && !tgt_sda_o);

    modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
                  input scl, sda);
    modport target (output tgt_sda_o, tgt_sda_oe, input scl, sda);
endinterface

// *** hdl/i2c_rd_pkg.sv ***
package i2c_rd_pkg;

    // target addresses of the two variants, and the direction bit values
    localparam logic [6:0] ADDR_MAIN = 7'h35;
    localparam logic [6:0] ADDR_ALT  = 7'h15;
    localparam logic       RW_WRITE  = 1'h0;
    localparam logic       RW_READ   = 1'h1;

    // default count of valid register indices; a received index at or above is refused
    localparam int REG_COUNT_DEF = 32'h0000_0010;

    // bit slots within a byte frame: eight data bits then the ack slot
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_ONE  = 4'h1;
    localparam logic [3:0] BIT_ACK  = 4'h8;

    // timing: bus clock limit and the reference clock
    localparam int SCL_MAX_KHZ    = 400;
    localparam int SCL_MIN_PER_NS = 1_000_000 / SCL_MAX_KHZ;
    localparam int CLK_PER_NS     = 20;
    localparam int QUARTERS       = 4;
    // a least time, so the quarter of a bus clock rounds up
    localparam int QUARTER_CYC    = (SCL_MIN_PER_NS + QUARTERS * CLK_PER_NS - 1)
                                    / (QUARTERS * CLK_PER_NS);
    localparam logic [5:0] QTR_LAST = 6'(QUARTER_CYC - 1);

    // quarter phases of one bus clock on the host side
    localparam logic [1:0] PH_SET  = 2'h0;
    localparam logic [1:0] PH_RISE = 2'h1;
    localparam logic [1:0] PH_HIGH = 2'h2;
    localparam logic [1:0] PH_FALL = 2'h3;

    // target states
    typedef enum logic [7:0] {
        T_IDLE   = 8'h01,
        T_ADDR   = 8'h02,
        T_INDEX  = 8'h04,
        T_ACK    = 8'h08,
        T_WAIT   = 8'h10,
        T_TX     = 8'h20,
        T_HACK   = 8'h40,
        T_IGNORE = 8'h80
    } tgt_state_e;

    // host states
    typedef enum logic [7:0] {
        H_IDLE   = 8'h01,
        H_START  = 8'h02,
        H_ADDR_W = 8'h04,
        H_INDEX  = 8'h08,
        H_RSTART = 8'h10,
        H_ADDR_R = 8'h20,
        H_READ   = 8'h40,
        H_STOP   = 8'h80
    } host_state_e;

endpackage

// *** hdl/i2c_read_host.sv ***
`timescale 1ns/1ns
module i2c_read_host #(
    parameter logic [6:0] TARGET_ADDR = i2c_rd_pkg::ADDR_MAIN
) (
    input  wire logic       ref_clk,   // 50 MHz clock
    input  wire logic       arst_n,    // async reset, active low
    i2c_link_if.host        link,      // two-wire bus side
    input  wire logic       cmd_valid, // request a read
    output logic            cmd_ready, // idle, request accepted when valid
    input  wire logic [7:0] cmd_index, // first register index
    input  wire logic [7:0] cmd_len,   // bytes to read, 0 reads one
    output logic      [7:0] rd_byte,   // received byte
    output logic            rd_valid,  // pulse: rd_byte new
    output logic            done,      // pulse: stop sent
    output logic            fail       // nak seen in last transfer
);

    ////////////////////////////////////////////////////////////////////////
    // quarter clock divider: four quarters give one bus clock within limit

    logic [5:0] qcnt;
    logic       tick;

    // bus clock no faster than the limit
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            qcnt <= 6'h00;
            tick <= 1'h0;
        end else begin
            tick <= (qcnt == i2c_rd_pkg::QTR_LAST);
            qcnt <= (qcnt == i2c_rd_pkg::QTR_LAST) ? 6'h00 : qcnt + 6'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // data line sampling: three stages, settled when the last two agree

    logic [2:0] sda_s;
    logic       sda_f;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_s <= 3'h7;
            sda_f <= 1'h1;
        end else begin
            sda_s <= {sda_s[1:0], link.sda};
            sda_f <= (sda_s[1] == sda_s[2]) ? sda_s[2] : sda_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer

    i2c_rd_pkg::host_state_e st;
    logic [1:0] ph;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] left;
    logic [7:0] index;
    logic       scl_oe;
    logic       sda_oe;

    wire tx_byte  = (st == i2c_rd_pkg::H_ADDR_W) || (st == i2c_rd_pkg::H_INDEX)
                    || (st == i2c_rd_pkg::H_ADDR_R);
    wire ack_slot = (bitn == i2c_rd_pkg::BIT_ACK);
    wire last     = (left == 8'h01);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st        <= i2c_rd_pkg::H_IDLE;
            ph        <= i2c_rd_pkg::PH_SET;
            bitn      <= i2c_rd_pkg::BIT_ZERO;
            sh        <= 8'h00;
            left      <= 8'h00;
            index     <= 8'h00;
            scl_oe    <= 1'h0;
            sda_oe    <= 1'h0;
            cmd_ready <= 1'h1;
            rd_byte   <= 8'h00;
            rd_valid  <= 1'h0;
            done      <= 1'h0;
            fail      <= 1'h0;
        end else begin
            rd_valid <= 1'h0;
            done     <= 1'h0;
            if (st == i2c_rd_pkg::H_IDLE) begin
                if (cmd_valid) begin
                    st        <= i2c_rd_pkg::H_START;
                    ph        <= i2c_rd_pkg::PH_SET;
                    cmd_ready <= 1'h0;
                    fail      <= 1'h0;
                    index     <= cmd_index;
                    left      <= (cmd_len == 8'h00) ? 8'h01 : cmd_len;
                    sh        <= {TARGET_ADDR, i2c_rd_pkg::RW_WRITE};
                end
            end else if (tick) begin
                ph <= ph + 2'h1;
                if (st == i2c_rd_pkg::H_START || st == i2c_rd_pkg::H_RSTART) begin
                    // both start kinds: data falls with clock high
                    case (ph)
                        i2c_rd_pkg::PH_SET:  sda_oe <= 1'h0;
                        i2c_rd_pkg::PH_RISE: scl_oe <= 1'h0;
                        i2c_rd_pkg::PH_HIGH: sda_oe <= 1'h1;
                        default: begin
                            scl_oe <= 1'h1;
                            bitn   <= i2c_rd_pkg::BIT_ZERO;
                            st     <= (st == i2c_rd_pkg::H_START)
                                      ? i2c_rd_pkg::H_ADDR_W : i2c_rd_pkg::H_ADDR_R;
                        end
                    endcase
                end else if (st == i2c_rd_pkg::H_STOP) begin
                    case (ph)
                        i2c_rd_pkg::PH_SET:  sda_oe <= 1'h1;
                        i2c_rd_pkg::PH_RISE: scl_oe <= 1'h0;
                        i2c_rd_pkg::PH_HIGH: sda_oe <= 1'h0;
                        default: begin
                            st        <= i2c_rd_pkg::H_IDLE;
                            cmd_ready <= 1'h1;
                            done      <= 1'h1;
                        end
                    endcase
                end else begin
                    // data set only while the clock is low
                    case (ph)
                        i2c_rd_pkg::PH_SET: begin
                            // ack all but the last byte
                            if (tx_byte) begin
                                sda_oe <= !ack_slot && !sh[7];
                            end else begin
                                sda_oe <= ack_slot && !last;
                            end
                        end
                        i2c_rd_pkg::PH_RISE: scl_oe <= 1'h0;
                        i2c_rd_pkg::PH_HIGH: begin
                            if (!ack_slot) begin
                                sh <= tx_byte ? {sh[6:0], 1'h0} : {sh[6:0], sda_f};
                            end else if (tx_byte && sda_f) begin
                                fail <= 1'h1;
                            end
                        end
                        default: begin
                            scl_oe <= 1'h1;
                            bitn   <= bitn + i2c_rd_pkg::BIT_ONE;
                            if (ack_slot) begin
                                bitn <= i2c_rd_pkg::BIT_ZERO;
                                if (fail || (tx_byte && sda_f)) begin
                                    st <= i2c_rd_pkg::H_STOP;
                                end else if (st == i2c_rd_pkg::H_ADDR_W) begin
                                    st <= i2c_rd_pkg::H_INDEX;
                                    sh <= index;
                                end else if (st == i2c_rd_pkg::H_INDEX) begin
                                    st <= i2c_rd_pkg::H_RSTART;
                                    sh <= {TARGET_ADDR, i2c_rd_pkg::RW_READ};
                                end else if (st == i2c_rd_pkg::H_ADDR_R) begin
                                    st <= i2c_rd_pkg::H_READ;
                                end else begin
                                    // nak sent on last, then stop
                                    rd_byte  <= sh;
                                    rd_valid <= 1'h1;
                                    left     <= left - 8'h01;
                                    st       <= last ? i2c_rd_pkg::H_STOP
                                                     : i2c_rd_pkg::H_READ;
                                end
                            end
                        end
                    endcase
                end
            end
        end
    end

    // open drain: enable pulls low, release reads high
    assign link.host_scl_o  = 1'h0;
    assign link.host_scl_oe = scl_oe;
    assign link.host_sda_o  = 1'h0;
    assign link.host_sda_oe = sda_oe;

endmodule

// *** hdl/i2c_read_target.sv ***
`timescale 1ns/1ns
module i2c_read_target #(
    parameter logic [6:0] TARGET_ADDR = i2c_rd_pkg::ADDR_MAIN,
    parameter int         REG_COUNT   = i2c_rd_pkg::REG_COUNT_DEF
) (
    input  wire logic       ref_clk,   // 50 MHz clock
    input  wire logic       arst_n,    // async reset, active low
    i2c_link_if.target      link,      // two-wire bus side
    output logic      [7:0] rd_index,  // register index being read
    input  wire logic [7:0] rd_data,   // register value at rd_index
    output logic            rd_strobe, // pulse: rd_data taken for sending
    output logic            busy,      // transfer between start and stop
    output logic            idx_error  // pulse: index refused
);

    ////////////////////////////////////////////////////////////////////////
    // input conditioning

    // a filtered level follows only once second and third stage agree
    function automatic logic settle(input logic s2, input logic s3, input logic cur);
        settle = (s2 == s3) ? s3 : cur;
    endfunction

    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic       scl_f;
    logic       sda_f;
    logic       scl_q;
    logic       sda_q;

    // three stages per pin; stage 0 feeds stage 1 only
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_s <= 3'h7;
            sda_s <= 3'h7;
            scl_f <= 1'h1;
            sda_f <= 1'h1;
            scl_q <= 1'h1;
            sda_q <= 1'h1;
        end else begin
            scl_s <= {scl_s[1:0], link.scl};
            sda_s <= {sda_s[1:0], link.sda};
            scl_f <= settle(scl_s[1], scl_s[2], scl_f);
            sda_f <= settle(sda_s[1], sda_s[2], sda_f);
            scl_q <= scl_f;
            sda_q <= sda_f;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // bus events

    wire scl_rise = scl_f && !scl_q;
    wire scl_fall = !scl_f && scl_q;
    wire start_c  = scl_f && scl_q && sda_q && !sda_f;
    wire stop_c   = scl_f && scl_q && !sda_q && sda_f;

    ////////////////////////////////////////////////////////////////////////
    // decoding of the received byte

    i2c_rd_pkg::tgt_state_e st;
    i2c_rd_pkg::tgt_state_e nxt;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic       sda_oe;
    logic       sda_o;

    wire addr_hit  = (sh[7:1] == TARGET_ADDR);
    wire rw_read   = (sh[0] == i2c_rd_pkg::RW_READ);
    wire idx_ok    = ({24'h00_0000, sh} < 32'(REG_COUNT));
    wire byte_done = scl_fall && (cnt == i2c_rd_pkg::BIT_ACK);
    wire more_bits = (cnt < i2c_rd_pkg::BIT_ACK);
    logic [7:0] next_index;
    assign next_index = rd_index + 8'h01;

    ////////////////////////////////////////////////////////////////////////
    // transfer engine; the data line only ever changes on a clock fall,
    // so every bit stays stable across the high phase

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            st        <= i2c_rd_pkg::T_IDLE;
            nxt       <= i2c_rd_pkg::T_IDLE;
            cnt       <= i2c_rd_pkg::BIT_ZERO;
            sh        <= 8'h00;
            sda_oe    <= 1'h0;
            sda_o     <= 1'h0;
            rd_index  <= 8'h00;
            rd_strobe <= 1'h0;
            busy      <= 1'h0;
            idx_error <= 1'h0;
        end else begin
            rd_strobe <= 1'h0;
            idx_error <= 1'h0;
            // a start always wins over ignore
            if (start_c) begin
                st     <= i2c_rd_pkg::T_ADDR;
                cnt    <= i2c_rd_pkg::BIT_ZERO;
                sda_oe <= 1'h0;
                busy   <= 1'h1;
            end else if (stop_c) begin
                st     <= i2c_rd_pkg::T_IDLE;
                sda_oe <= 1'h0;
                busy   <= 1'h0;
            end else begin
                case (st)
                    i2c_rd_pkg::T_ADDR: begin
                        if (scl_rise) begin
                            sh  <= {sh[6:0], sda_f};
                            cnt <= cnt + i2c_rd_pkg::BIT_ONE;
                        end
                        if (byte_done) begin
                            cnt <= i2c_rd_pkg::BIT_ZERO;
                            if (addr_hit) begin
                                st     <= i2c_rd_pkg::T_ACK;
                                sda_oe <= 1'h1;
                                nxt    <= rw_read ? i2c_rd_pkg::T_TX
                                                  : i2c_rd_pkg::T_INDEX;
                            end else begin
                                st <= i2c_rd_pkg::T_IGNORE;
                            end
                        end
                    end
                    i2c_rd_pkg::T_INDEX: begin
                        if (scl_rise) begin
                            sh  <= {sh[6:0], sda_f};
                            cnt <= cnt + i2c_rd_pkg::BIT_ONE;
                        end
                        if (byte_done) begin
                            cnt <= i2c_rd_pkg::BIT_ZERO;
                            if (idx_ok) begin
                                st       <= i2c_rd_pkg::T_ACK;
                                sda_oe   <= 1'h1;
                                rd_index <= sh;
                                nxt      <= i2c_rd_pkg::T_WAIT;
                            end else begin
                                st        <= i2c_rd_pkg::T_IGNORE;
                                idx_error <= 1'h1;
                            end
                        end
                    end
                    // low through the ninth high phase
                    i2c_rd_pkg::T_ACK: begin
                        if (scl_fall) begin
                            st     <= nxt;
                            sda_oe <= 1'h0;
                            if (nxt == i2c_rd_pkg::T_TX) begin
                                sh        <= rd_data;
                                sda_oe    <= !rd_data[7];
                                rd_strobe <= 1'h1;
                            end
                        end
                    end
                    i2c_rd_pkg::T_TX: begin
                        if (scl_rise) begin
                            cnt <= cnt + i2c_rd_pkg::BIT_ONE;
                        end
                        if (scl_fall && more_bits) begin
                            sh     <= {sh[6:0], 1'h0};
                            sda_oe <= !sh[6];
                        end
                        if (byte_done) begin
                            sda_oe <= 1'h0;
                            st     <= i2c_rd_pkg::T_HACK;
                        end
                    end
                    i2c_rd_pkg::T_HACK: begin
                        // advance on ack, stay off on nak
                        if (scl_rise) begin
                            if (!sda_f) begin
                                rd_index <= next_index;
                            end else begin
                                st <= i2c_rd_pkg::T_IGNORE;
                            end
                        end
                        if (scl_fall) begin
                            st        <= i2c_rd_pkg::T_TX;
                            cnt       <= i2c_rd_pkg::BIT_ZERO;
                            sh        <= rd_data;
                            sda_oe    <= !rd_data[7];
                            rd_strobe <= 1'h1;
                        end
                    end
                    default: begin
                        // idle, waiting for restart, or ignoring: line released
                        sda_oe <= 1'h0;
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pin drive: open drain, the enable pulls the line low

    assign link.tgt_sda_o  = sda_o;
    assign link.tgt_sda_oe = sda_oe;

endmodule

// *** sim/i2c_read_target_sva.sv ***
`timescale 1ns/1ns
module i2c_read_target_sva #(
    parameter logic [6:0] TARGET_ADDR = i2c_rd_pkg::ADDR_MAIN,
    parameter int         REG_COUNT   = i2c_rd_pkg::REG_COUNT_DEF
) (
    input wire logic ref_clk,     // clock
    input wire logic arst_n,      // reset
    input wire logic host_scl_o,  // host clock level
    input wire logic host_scl_oe, // host clock pull
    input wire logic host_sda_o,  // host data level
    input wire logic host_sda_oe, // host data pull
    input wire logic tgt_sda_o,   // target data level
    input wire logic tgt_sda_oe,  // target data pull
    input wire logic scl,         // clock wire
    input wire logic sda          // data wire
);
    logic       scl_q, sda_q, wr_ok, rd_ph;
    logic [3:0] bit_cnt;
    logic [7:0] byte_no, sh, per_cnt;
    // bus events from one sample to the next; a start is data falling in clock high
    wire       scl_rise   = scl && !scl_q;
    wire       scl_fall   = !scl && scl_q;
    wire       start_seen = scl && scl_q && sda_q && !sda;
    wire       ack_slot   = scl_rise && bit_cnt == 4'h8;
    wire       first_ack  = ack_slot && byte_no == 8'h00;
    wire       addr_hit   = sh[7:1] == TARGET_ADDR;
    wire [7:0] next_per   = scl_fall ? 8'h00 : per_cnt + 8'(per_cnt != 8'hff);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    ////////////////////////////////////////////////////////////
    // history and period count; it saturates so long idle never wraps
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {scl_q, sda_q, per_cnt} <= 10'h3ff;
        end else begin
            {scl_q, sda_q, per_cnt} <= {scl, sda, next_per};
        end
    end
    // bit and byte position since the last start, with the byte shifted in
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            {bit_cnt, byte_no, sh, wr_ok, rd_ph} <= '0;
        end else if (start_seen) begin
            {bit_cnt, byte_no} <= '0;
        end else if (scl_rise) begin
            bit_cnt <= ack_slot ? 4'h0 : bit_cnt + 4'h1;
            byte_no <= byte_no + 8'(ack_slot);
            sh      <= ack_slot ? sh : {sh[6:0], sda};
            wr_ok   <= first_ack ? addr_hit && !sh[0] : wr_ok;
            rd_ph   <= first_ack ? addr_hit && sh[0] : rd_ph;
        end
    end
    ////////////////////////////////////////////////////////////
    property p_sda_hold; scl && scl_q |-> $stable(tgt_sda_oe); endproperty
    a_sda_hold: assert property (p_sda_hold) else $error("target moved in clock high");
    property p_ack_low; tgt_sda_oe |-> !tgt_sda_o && !sda; endproperty
    a_ack_low: assert property (p_ack_low) else $error("target pull not low");
    property p_turn_low; $changed(tgt_sda_oe) |-> !scl && !scl_q; endproperty
    a_turn_low: assert property (p_turn_low) else $error("target turned outside low");
    property p_turn_delay; $changed(tgt_sda_oe) |-> !$past(scl, 3) && $past(scl, 6); endproperty
    a_turn_delay: assert property (p_turn_delay) else $error("target turn late");
    property p_scl_rate; scl_fall |-> per_cnt >= 8'h7c; endproperty
    a_scl_rate: assert property (p_scl_rate) else $error("bus clock too fast");
    property p_addr_ack; first_ack |-> tgt_sda_oe == addr_hit; endproperty
    a_addr_ack: assert property (p_addr_ack) else $error("address ack wrong");
    property p_idx_ack; ack_slot && byte_no == 8'h01 && wr_ok
        |-> tgt_sda_oe == (sh < REG_COUNT); endproperty
    a_idx_ack: assert property (p_idx_ack) else $error("index ack wrong");
    property p_host_slot; ack_slot && rd_ph && byte_no != 8'h00 |-> !tgt_sda_oe; endproperty
    a_host_slot: assert property (p_host_slot) else $error("target held host slot");
    // the host must leave the line free while the target answers its bytes
    property p_host_free; ack_slot && (byte_no == 8'h00 || wr_ok) |-> !host_sda_oe; endproperty
    a_host_free: assert property (p_host_free) else $error("host held target slot");
endmodule

// *** sim/i2c_register_read_target_test.sv ***
`timescale 1ns/1ns
module i2c_register_read_target_test;
    logic       ref_clk, arst_n, cmd_valid, alt_valid, alt_done, alt_fail;
    logic       cmd_ready, rd_valid, done, fail, rd_strobe, busy, idx_error;
    logic [7:0] cmd_index, cmd_len, rd_byte, rd_index;
    int         err_count = 0;
    int         compares  = 0;
    // main pair, and a host calling the foreign variant address
    i2c_link_if i2c_link_if_inst ();
    i2c_link_if i2c_link_if_alt ();
    i2c_read_host i2c_read_host_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .link(i2c_link_if_inst.host), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
        .cmd_index(cmd_index), .cmd_len(cmd_len), .rd_byte(rd_byte),
        .rd_valid(rd_valid), .done(done), .fail(fail));
    i2c_read_target #(.REG_COUNT(16)) i2c_read_target_inst (.ref_clk(ref_clk),
        .arst_n(arst_n), .link(i2c_link_if_inst.target), .rd_index(rd_index),
        .rd_data(rd_index ^ 8'ha5), .rd_strobe(rd_strobe), .busy(busy),
        .idx_error(idx_error));
    i2c_read_host #(.TARGET_ADDR(i2c_rd_pkg::ADDR_ALT)) i2c_read_host_alt (
        .ref_clk(ref_clk), .arst_n(arst_n), .link(i2c_link_if_alt.host),
        .cmd_valid(alt_valid), .cmd_ready(), .cmd_index(cmd_index),
        .cmd_len(cmd_len), .rd_byte(), .rd_valid(), .done(alt_done), .fail(alt_fail));
    i2c_read_target i2c_read_target_alt (.ref_clk(ref_clk), .arst_n(arst_n),
        .link(i2c_link_if_alt.target), .rd_index(), .rd_data(8'h00),
        .rd_strobe(), .busy(), .idx_error());
    i2c_read_target_sva #(.TARGET_ADDR(i2c_rd_pkg::ADDR_MAIN), .REG_COUNT(16))
        i2c_read_target_sva_inst (.ref_clk(ref_clk), .arst_n(arst_n),
        .host_scl_o(i2c_link_if_inst.host_scl_o), .host_scl_oe(i2c_link_if_inst.host_scl_oe),
        .host_sda_o(i2c_link_if_inst.host_sda_o), .host_sda_oe(i2c_link_if_inst.host_sda_oe),
        .tgt_sda_o(i2c_link_if_inst.tgt_sda_o), .tgt_sda_oe(i2c_link_if_inst.tgt_sda_oe),
        .scl(i2c_link_if_inst.scl), .sda(i2c_link_if_inst.sda));
    ////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic results;
        $display("compares %0d err_count %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // one read command; bytes are checked as they arrive, counts at the end
    task automatic read_regs(input logic [7:0] idx, input logic [7:0] len, input logic bad);
        logic [7:0] n, s, e, r;
        int         t;
        {n, s, e} = 24'h00_0000;
        t = 0;
        r = rd_index;
        cmd_index = idx;
        cmd_len   = len;
        cmd_valid = 1'b1;
        @(negedge ref_clk);
        cmd_valid = 1'b0;
        check("cmd_ready", 8'(cmd_ready), 8'h00);
        while (done !== 1'b1 && t < 32'h0000_4e20) begin
            @(negedge ref_clk);
            if (rd_valid === 1'b1) begin
                check("rd_byte", rd_byte, (idx + n) ^ 8'ha5);
                check("busy", 8'(busy), 8'h01);
                n++;
            end
            s += 8'(rd_strobe === 1'b1);
            e += 8'(idx_error === 1'b1);
            t++;
        end
        len = (len == 8'h00) ? 8'h01 : len;
        check("bytes", n, bad ? 8'h00 : len);
        check("strobes", s, bad ? 8'h00 : len);
        check("idx_error", e, 8'(bad));
        check("fail", 8'(fail), 8'(bad));
        check("idle", {6'h00, i2c_link_if_inst.scl, i2c_link_if_inst.sda}, 8'h03);
        // a loop that ran out of time leaves done low and counts as a mismatch
        check("done", 8'(done), 8'h01);
        check("cmd_ready", 8'(cmd_ready), 8'h01);
        check("rd_index", rd_index, bad ? r : idx + len - 8'h01);
    endtask
    ////////////////////////////////////////////////////////////
    // free running clock
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    // watchdog, well beyond the expected run length
    initial begin
        repeat (32'h0001_3880) @(posedge ref_clk);
        err_count++;
        results();
    end
    // reset, then back to back reads; the foreign address goes last
    initial begin
        int t;
        t = 0;
        {arst_n, cmd_valid, alt_valid, cmd_index, cmd_len} = 19'h0_0000;
        repeat (5) @(negedge ref_clk);
        arst_n = 1'b1;
        read_regs(8'h03, 8'h01, 1'b0);
        read_regs(8'h0c, 8'h04, 1'b0);
        read_regs(8'h00, 8'h00, 1'b0);
        read_regs(8'h10, 8'h01, 1'b1);
        read_regs(8'h0f, 8'h03, 1'b0);
        read_regs(8'hff, 8'h01, 1'b1);
        alt_valid = 1'b1;
        @(negedge ref_clk);
        alt_valid = 1'b0;
        while (alt_done !== 1'b1 && t < 32'h0000_4e20) begin
            @(negedge ref_clk);
            t++;
        end
        check("alt_done", 8'(alt_done), 8'h01);
        check("alt_fail", 8'(alt_fail), 8'h01);
        results();
    end
endmodule
